// ===== ssl_map.svh
// ssl_map.svh: bit positions, select codes and timing counts for the serial load port
// assumes: included by bare name wherever these constants are needed
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH
`define SSL_WORD_BITS 24
`define SSL_BYTE_BITS 8
`define SSL_SEL_REF 2'h0
`define SSL_SEL_DIV 2'h1
`define SSL_SEL_FUNC 2'h2
`define SSL_CRST_POS 2
`define SSL_PDN_POS 3
`define SSL_CPTRI_POS 8
// register offsets of the host controller, byte addresses on apb
`define SSL_ADDR_DATA 12'h000
`define SSL_ADDR_CTRL 12'h004
`define SSL_ADDR_STAT 12'h008
// ctrl bits
`define SSL_CTRL_START 0
`define SSL_CTRL_CE 1
// sclk divider: half period in pclk cycles (40 MHz / 4 = 10 MHz, under 20 MHz)
`define SSL_SCLK_HALF 2
// settling time after chip enable rises, in ns, and its count at 25 ns pclk
`define SSL_SETTLE_NS 1000
`define SSL_PCLK_NS 25
`define SSL_SETTLE_CYC ((`SSL_SETTLE_NS + `SSL_PCLK_NS - 1) / `SSL_PCLK_NS)
`endif

// ===== ssl_pkg.sv
// ssl_pkg.sv: types for the host end of the serial load link
// assumes: nothing beyond a systemverilog compiler
package ssl_pkg;
    // host sequencer states, one-hot
    typedef enum logic [3:0] {
        SSL_IDLE = 4'b0001,
        SSL_SHIFT = 4'b0010,
        SSL_STROBE = 4'b0100,
        SSL_DONE = 4'b1000
    } ssl_state_type;
    typedef logic [23:0] ssl_word_type;
endpackage

// ===== ssl_link_if.sv
// ssl_link_if.sv: three-wire serial load link plus chip enable
// assumes: the host drives every wire; the device only listens
`timescale 1ns/100ps
`default_nettype none
interface ssl_link_if;
    logic sclk; // serial clock from host
    logic sdata; // serial data, msb first
    logic load_strobe; // rising edge latches the word
    logic chip_en; // low powers the device down
    modport host (output sclk, output sdata, output load_strobe, output chip_en);
    modport dev (input sclk, input sdata, input load_strobe, input chip_en);
endinterface
`default_nettype wire

// ===== ssl_host.sv
// ssl_host.sv: apb-programmed host end, shifts words out and drives chip enable
// it divides pclk down to make the serial clock and drives every link wire itself
// assumes: pclk 40 MHz; software orders the init sequences through data/ctrl writes
// assumes: software polls busy before each start and settled after chip enable rises
// assumes: the device end needs no reset wire, it only listens to the link
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ssl_map.svh"
module ssl_host (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link
    ssl_link_if.host link
);
    ssl_pkg::ssl_state_type state_reg; // sequencer state
    ssl_pkg::ssl_state_type state_next; // its next value
    logic [23:0] data_reg; // word software wants to send
    logic [23:0] shift_reg; // outgoing bits, msb at top
    logic [4:0] bit_cnt_reg; // bits still to send
    logic [1:0] div_reg; // sclk half period counter
    logic sclk_reg; // serial clock, idles low between words
    logic sdata_reg; // serial data, changes only while sclk is low
    logic strobe_reg; // load strobe, low from start until the word is out
    logic ce_reg; // chip enable, resets low so the device starts powered down
    logic [5:0] settle_reg; // counts settling time after chip enable rises
    logic [31:0] prdata_reg; // read data, zero outside the answer cycle
    logic pready_reg; // one-cycle answer pulse
    logic pslverr_reg; // error flag, rides with pready on an unmapped address

    // decode: the first access edge loads the answer, one wait state in all
    wire access = psel && penable && !pready_reg;
    // a write lands only at the edge that samples pready high, with the request still held
    wire answer_edge = psel && penable && pready_reg;
    // address decode, one aligned word per register
    wire sel_data = paddr == `SSL_ADDR_DATA;
    wire sel_ctrl = paddr == `SSL_ADDR_CTRL;
    wire sel_stat = paddr == `SSL_ADDR_STAT;
    wire mapped = sel_data || sel_ctrl || sel_stat;
    // write strobes, taken in the answer cycle
    wire wr_data = answer_edge && pwrite && sel_data;
    wire wr_ctrl = answer_edge && pwrite && sel_ctrl;
    // sequencer status
    wire busy = state_reg != ssl_pkg::SSL_IDLE;
    // start ignored while busy, software polls busy first; a dropped start is not flagged
    wire start = wr_ctrl && pwdata[`SSL_CTRL_START] && !busy;
    // serial timing: the divider wraps once per sclk half period
    wire div_wrap = div_reg == 2'(`SSL_SCLK_HALF - 1);
    // settled reads high once the bias settling count has run out
    wire settled = settle_reg == 6'h00;
    // status and read mux
    wire [31:0] stat_word = {30'h0000_0000, settled, busy};
    wire [31:0] rd_word = sel_data ? {8'h00, data_reg} :
        sel_ctrl ? {30'h0000_0000, ce_reg, 1'b0} : sel_stat ? stat_word : 32'h0000_0000;

    // apb answer registers
    // pready drops again at its own edge, so a held access phase answers again every second cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle bus: no answer pending
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            // read data is captured one edge early so it stands while pready is high
            pready_reg <= psel && penable && !pready_reg;
            pslverr_reg <= access && !mapped;
            prdata_reg <= (access && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // software registers; chip enable is a plain level, ordering is software's job
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg <= 24'h00_0000;
            ce_reg <= 1'b0;
            settle_reg <= 6'h00;
        end else begin
            // the word is copied into the shifter at start, so software may refill it
            if (wr_data) begin
                data_reg <= pwdata[23:0];
            end
            // chip enable follows the ctrl bit; power-down needs software to drop it first
            if (wr_ctrl) begin
                ce_reg <= pwdata[`SSL_CTRL_CE];
            end
            // a rising chip enable restarts the settling count, a fresh load wins
            if (wr_ctrl && pwdata[`SSL_CTRL_CE] && !ce_reg) begin
                settle_reg <= 6'(`SSL_SETTLE_CYC);
            end else if (!settled) begin
                // count down to zero and stop there
                settle_reg <= settle_reg - 6'h01;
            end
        end
    end

    // sequencer next state
    // past idle it only moves on divider wraps, so every sclk and strobe edge is two pclk apart
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ssl_pkg::SSL_IDLE: begin
                // wait for software to write start
                if (start) begin
                    state_next = ssl_pkg::SSL_SHIFT;
                end
            end
            ssl_pkg::SSL_SHIFT: begin
                // the last falling edge ends the third byte
                if (div_wrap && sclk_reg && bit_cnt_reg == 5'h01) begin
                    state_next = ssl_pkg::SSL_STROBE;
                end
            end
            ssl_pkg::SSL_STROBE: begin
                // half a period of quiet after the last fall, then the strobe rises
                if (div_wrap) begin
                    state_next = ssl_pkg::SSL_DONE;
                end
            end
            ssl_pkg::SSL_DONE: begin
                // strobe stays high one half period, then the port is free
                if (div_wrap) begin
                    state_next = ssl_pkg::SSL_IDLE;
                end
            end
            default: begin
                // an illegal code falls back to idle
                state_next = ssl_pkg::SSL_IDLE;
            end
        endcase
    end

    // serial engine: clock divided from pclk, data changes on the falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ssl_pkg::SSL_IDLE;
            shift_reg <= 24'h00_0000;
            bit_cnt_reg <= 5'h00;
            div_reg <= 2'h0;
            sclk_reg <= 1'b0;
            sdata_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // the divider rests at zero in idle so every word starts with a full half period
            div_reg <= (state_reg == ssl_pkg::SSL_IDLE || div_wrap) ? 2'h0 : div_reg + 2'h1;
            // start: load the shifter and present bit 23 before the first rising sclk
            if (start) begin
                strobe_reg <= 1'b0;
                shift_reg <= {data_reg[22:0], 1'b0};
                sdata_reg <= data_reg[23];
                bit_cnt_reg <= 5'(`SSL_WORD_BITS);
            end else if (state_reg == ssl_pkg::SSL_SHIFT && div_wrap) begin
                // each wrap toggles sclk; the device samples on the rise
                sclk_reg <= !sclk_reg;
                if (sclk_reg) begin
                    // falling edge: present next bit half a period ahead
                    sdata_reg <= shift_reg[23];
                    shift_reg <= {shift_reg[22:0], 1'b0};
                    bit_cnt_reg <= bit_cnt_reg - 5'h01;
                end
            end else if (state_reg == ssl_pkg::SSL_STROBE && div_wrap) begin
                // the third byte is out: raise the strobe to latch the word
                strobe_reg <= 1'b1;
            end else if (state_reg == ssl_pkg::SSL_DONE && div_wrap) begin
                // drop the strobe so the next word starts from low
                strobe_reg <= 1'b0;
            end
        end
    end

    // every output comes straight from its flip-flop
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    // link wires; the device end is clocked by sclk and the load strobe
    assign link.sclk = sclk_reg;
    assign link.sdata = sdata_reg;
    assign link.load_strobe = strobe_reg;
    assign link.chip_en = ce_reg;
endmodule
`default_nettype wire

// ===== ssl_dev.sv
// ssl_dev.sv: device end, 24-bit input register, three latches, power-down and counter reset
// assumes: sclk and the load strobe are the only clocks here; chip enable acts without any clock
`timescale 1ns/100ps
`default_nettype none
`include "ssl_map.svh"
module ssl_dev (
    // link
    ssl_link_if.dev link,
    // latch contents
    output logic [23:0] ref_latch,
    output logic [23:0] div_latch,
    output logic [23:0] func_latch,
    // state seen by the synthesizer core
    output logic power_down,
    output logic counters_held,
    output logic charge_pump_tristate
);
    logic [23:0] in_reg; // input register, keeps running while powered down
    logic [23:0] ref_reg, div_reg, func_reg;

    // shift msb first on every rising sclk, power-down does not stop it
    always_ff @(posedge link.sclk) begin
        in_reg <= {in_reg[22:0], link.sdata};
    end

    // latch transfer on the strobe edge only; no reset so programming persists
    always_ff @(posedge link.load_strobe) begin
        case (in_reg[1:0])
            `SSL_SEL_REF: ref_reg <= in_reg;
            `SSL_SEL_DIV: div_reg <= in_reg;
            `SSL_SEL_FUNC: func_reg <= in_reg;
            default: ref_reg <= ref_reg; // select 11 is not a latch
        endcase
    end

    // chip enable low forces power-down, counter hold and cp three-state at once, no clock involved; the latches still load
    wire pdn = !link.chip_en || func_reg[`SSL_PDN_POS];
    wire crst = func_reg[`SSL_CRST_POS];
    // counters restart together the moment both holds drop
    assign counters_held = pdn || crst;
    assign charge_pump_tristate = counters_held || func_reg[`SSL_CPTRI_POS];
    assign power_down = pdn;
    assign ref_latch = ref_reg;
    assign div_latch = div_reg;
    assign func_latch = func_reg;
endmodule
`default_nettype wire

// ===== ssl_link_props.sv
// ssl_link_props.sv: wire and latch rules of the serial load link
// assumes: instantiated beside the link, everything sampled on pclk
`timescale 1ns/100ps
`default_nettype none
`include "ssl_map.svh"
module ssl_link_props (
    // host clock domain
    input wire logic pclk,
    input wire logic presetn,
    // link wires
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic chip_en,
    // device state
    input wire logic [23:0] ref_latch,
    input wire logic [23:0] div_latch,
    input wire logic [23:0] func_latch,
    input wire logic power_down,
    input wire logic counters_held,
    input wire logic charge_pump_tristate
);
    logic [23:0] shadow_reg; // word as it crossed the wire
    logic [5:0] bits_reg; // sclk rises since the last strobe
    logic seen_reg; // set once a word is latched; first load is a function word
    wire logic [1:0] sel = shadow_reg[1:0];
    wire logic [23:0] picked = (sel == 2'h0) ? ref_latch : (sel == 2'h1) ? div_latch :
        (sel == 2'h2) ? func_latch : shadow_reg;
    // sdata is steady at each sclk rise, so sampling on pclk sees what the device sees
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_reg <= 24'h00_0000;
            bits_reg <= 6'h00;
            seen_reg <= 1'b0;
        end else begin
            if ($rose(sclk)) shadow_reg <= {shadow_reg[22:0], sdata};
            bits_reg <= $rose(load_strobe) ? 6'h00 : bits_reg + {5'h00, $rose(sclk)};
            if ($rose(load_strobe)) seen_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_strobe_low_shift: assert property ($rose(sclk) |-> !load_strobe)
        else $error("strobe high during shifting");
    a_data_phase: assert property ($changed(sdata) |-> !sclk)
        else $error("data moved while sclk high");
    a_sclk_rate: assert property ($changed(sclk) |=> $stable(sclk))
        else $error("sclk half period too short");
    a_strobe_pulse: assert property ($rose(load_strobe) |=> load_strobe ##[1:4] !load_strobe)
        else $error("strobe pulse malformed");
    a_word_bits: assert property ($rose(load_strobe) |-> bits_reg == 6'h18)
        else $error("word not 24 bits");
    a_latch_load: assert property ($rose(load_strobe) |-> picked == shadow_reg)
        else $error("latch differs from word sent");
    a_latch_hold: assert property (seen_reg && !load_strobe |-> $stable(func_latch))
        else $error("function latch moved without strobe");
    a_ce_down: assert property (!chip_en |-> power_down)
        else $error("chip enable low but running");
    a_crst_hold: assert property (chip_en && func_latch[`SSL_CRST_POS] |->
        counters_held && charge_pump_tristate && power_down == func_latch[`SSL_PDN_POS])
        else $error("counter reset not holding");
    a_crst_free: assert property (chip_en && func_latch[3:2] == 2'h0 |-> !power_down &&
        !counters_held && charge_pump_tristate == func_latch[`SSL_CPTRI_POS])
        else $error("counters not released");
    // main scenarios reached
    cover property ($rose(load_strobe) && sel == 2'h2);
    cover property ($rose(chip_en));
    cover property (chip_en && counters_held);
endmodule
`default_nettype wire

// ===== test_synth_serial_load_and_init.sv
// test_synth_serial_load_and_init.sv: apb stimulus, latch scoreboard, verdict
// assumes: host, device, link interface and checker compiled before this file
`timescale 1ns/100ps
`default_nettype none
`include "ssl_map.svh"
module test_synth_serial_load_and_init;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [23:0] ref_latch, div_latch, func_latch, m_ref, m_div, m_func;
    logic power_down, counters_held, charge_pump_tristate;
    logic [32:0] q_rd[$]; // expected {pslverr, prdata}
    logic [71:0] q_lt[$]; // expected latches after each strobe
    int n_mismatch, n_tests, seed;
    ssl_link_if link();
    ssl_host ssl_host_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .link(link));
    ssl_dev ssl_dev_i(.link(link), .ref_latch, .div_latch, .func_latch, .power_down,
        .counters_held, .charge_pump_tristate);
    ssl_link_props ssl_link_props_i(.pclk, .presetn, .sclk(link.sclk), .sdata(link.sdata),
        .load_strobe(link.load_strobe), .chip_en(link.chip_en), .ref_latch, .div_latch,
        .func_latch, .power_down, .counters_held, .charge_pump_tristate);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task rd(input logic [11:0] a, input logic [32:0] x);
        q_rd.push_back(x);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task poll(input int i, input logic v);
        do apb(1'b0, `SSL_ADDR_STAT, 32'h0000_0000); while (r[i] !== v);
    endtask
    task ce(input logic v);
        apb(1'b1, `SSL_ADDR_CTRL, {30'h0000_0000, v, 1'b0});
    endtask
    // model the selected latch, then shift the word out
    task send(input logic [23:0] w, input logic c);
        case (w[1:0])
            `SSL_SEL_REF: m_ref = w;
            `SSL_SEL_DIV: m_div = w;
            `SSL_SEL_FUNC: m_func = w;
            default: ;
        endcase
        q_lt.push_back({m_ref, m_div, m_func});
        apb(1'b1, `SSL_ADDR_DATA, {8'h00, w});
        apb(1'b1, `SSL_ADDR_CTRL, {30'h0000_0000, c, 1'b1});
        poll(0, 1'b0);
    endtask
    // random word; f gives cp three-state, power-down, counter reset
    function logic [23:0] wd(input logic [1:0] s, input logic [2:0] f);
        wd = $random(seed);
        wd[8] = f[2];
        wd[3:2] = f[1:0];
        wd[1:0] = s;
    endfunction
    // watchers take the oldest note as each result appears
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && q_rd.size() > 0)
            check("read", {pslverr, prdata}, q_rd.pop_front());
    end
    always @(posedge link.load_strobe) begin
        #1;
        if (q_lt.size() > 0) check("latches", {ref_latch, div_latch, func_latch}, q_lt.pop_front());
    end
    task conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        conclude();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, n_mismatch, n_tests} = 0;
        seed = 42287;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`SSL_ADDR_CTRL, 33'h0_0000_0000);
        rd(12'h00c, 33'h1_0000_0000);
        apb(1'b1, 12'h00c, 32'h0000_0000);
        check("write error", e, 1'b1);
        apb(1'b1, `SSL_ADDR_DATA, 32'hffff_ffff);
        check("write ok", e, 1'b0);
        rd(`SSL_ADDR_DATA, 33'h0_00ff_ffff);
        $display("done: registers");
        check("pd", power_down, 1'b1);
        send(wd(2'h2, 3'h0), 1'b0);
        send(wd(2'h0, 3'h0), 1'b0);
        send(wd(2'h1, 3'h0), 1'b0);
        ce(1'b1);
        poll(1, 1'b1);
        check("run", {power_down, counters_held}, 2'b00);
        ce(1'b0);
        check("pd", power_down, 1'b1);
        ce(1'b1);
        check("kept", {ref_latch, div_latch, func_latch}, {m_ref, m_div, m_func});
        $display("done: chip enable method");
        send(wd(2'h2, 3'h1), 1'b1);
        send(wd(2'h0, 3'h0), 1'b1);
        send(wd(2'h1, 3'h0), 1'b1);
        send(wd(2'h3, 3'h0), 1'b1);
        check("held", {power_down, counters_held, charge_pump_tristate}, 3'b011);
        send(wd(2'h2, 3'h0), 1'b1);
        check("free", {power_down, counters_held, charge_pump_tristate}, 3'b000);
        $display("done: counter reset method");
        for (int f = 0; f < 8; f++) begin
            send(wd(2'h2, f[2:0]), 1'b1);
            check("fn", {power_down, counters_held, charge_pump_tristate},
                {f[1], f[1] | f[0], f[2] | f[1] | f[0]});
        end
        $display("done: function bits");
        conclude();
    end
endmodule
`default_nettype wire
